// *** logic/switch_host_pkg.sv ***
// Purpose: Shared constants and types for the bus switch host controller
// Assumes: 10 MHz system clock, 100 kHz serial clock on the switch bus
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus
package switch_host_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_NS       = 100;    // System clock period
	localparam int SCL_NS       = 10000;  // Serial clock period
	localparam int QTR_CYC      = SCL_NS / (4 * CLK_NS); // Quarter bit
	localparam int RST_PULSE_NS = 6;      // Least reset pulse at switch
	localparam int RST_CYC_RAW  = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC      = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int           AXI_AW      = 4;      // Address width
	localparam logic [3:0]   CTRL_OFS    = 4'h0;   // Command and target
	localparam logic [3:0]   WDATA_OFS   = 4'h4;   // Byte to write
	localparam logic [3:0]   STATUS_OFS  = 4'h8;   // Engine state
	localparam logic [3:0]   RDATA_OFS   = 4'hc;   // Last byte read
	localparam int           GO_WR_BIT   = 0;      // Start a write
	localparam int           GO_RD_BIT   = 1;      // Start a read
	localparam int           DEV_RST_BIT = 2;      // Pulse switch reset
	localparam int           CNT_LSB     = 4;      // Extra data bytes
	localparam int           SEL_LSB     = 8;      // Address select pins
	localparam int           ST_BUSY_BIT = 0;      // Transfer running
	localparam int           ST_NACK_BIT = 1;      // Address or data nack
	localparam int           ST_IRQ_BIT  = 2;      // Shared irq line low
	localparam int           ST_FLAG_LSB = 8;      // Flagged channels
	localparam int           ST_CONN_LSB = 12;     // Connected channels
	localparam int           CHAN_EN_LSB = 0;      // Control byte enables
	localparam int           CHAN_IRQ_LSB = 4;     // Control byte irqs
	localparam logic [1:0]   SEL_RST     = 2'h0;   // Address select reset
	localparam logic [1:0]   CNT_RST     = 2'h0;   // Byte count reset
	localparam logic [7:0]   WDATA_RST   = 8'h00;  // Write byte reset
	localparam logic [4:0]   DEV_ADDR_HI = 5'h1c;  // Fixed address bits
	localparam logic [1:0]   RESP_OKAY   = 2'h0;
	localparam logic [1:0]   RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		ST_IDLE, ST_RST, ST_WAIT_BUS, ST_START, ST_BIT, ST_STOP
	} state_type;

	typedef enum logic [1:0] {
		KIND_ADDR, KIND_TX, KIND_RX
	} kind_type;

endpackage

// *** logic/pin_view_if.sv ***
// Purpose: Synchronised view of the switch bus pins
// Assumes: Driven by line_sync, read by the host core
// Notes:   Every signal has passed two flip-flops
`timescale 1ns/10ps
interface pin_view_if;
	logic scl_s;    // Serial clock level
	logic sda_s;    // Serial data level
	logic irq_n_s;  // Shared interrupt line, low active

	modport sync_side (output scl_s, output sda_s, output irq_n_s);
	modport core_side (input scl_s, input sda_s, input irq_n_s);
endinterface

// *** logic/line_sync.sv ***
// Purpose: Two-stage synchronisers for the pins read by the host
// Assumes: Pins idle high through pull-ups
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module line_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Raw pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic irq_in_n,
	// Synchronised view
	pin_view_if.sync_side view
);
	logic [2:0] raw;        // Pins gathered
	logic [2:0] meta_reg;   // First stage
	logic [2:0] sync_reg;   // Second stage

	assign raw = {irq_in_n, sda_in, scl_in};

	// One synchroniser per pin, reset to the idle high level
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				meta_reg[i] <= 1'b1;
				sync_reg[i] <= 1'b1;
			end else begin
				meta_reg[i] <= raw[i];
				sync_reg[i] <= meta_reg[i];
			end
		end
	end

	assign view.scl_s   = sync_reg[0];
	assign view.sda_s   = sync_reg[1];
	assign view.irq_n_s = sync_reg[2];
endmodule

// *** logic/tick_div.sv ***
// Purpose: Divider giving a one-cycle enable per quarter serial bit
// Assumes: DIV of two or more
// Notes:   Free running from reset release
`timescale 1ns/10ps
module tick_div #(
	parameter int DIV = 25
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Enable pulse
	output logic      tick
);
	logic [15:0] cnt_reg;   // Cycles left to the next pulse

	// Count down and reload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 16'h0000;
		end else if (cnt_reg == 16'h0000) begin
			cnt_reg <= 16'(DIV - 1);
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	assign tick = (cnt_reg == 16'h0000);
endmodule

// *** logic/switch_host.sv ***
// Purpose: Serial bus controller that programs and polls a bus switch
// Assumes: Software drives it over AXI4-Lite; switch bus pulled up
// Notes:   One transfer at a time; commands while busy are ignored
`timescale 1ns/10ps

// Operation
// R1: Start only while both lines idle high
// R2: Data changes only while clock is low
// R3: Data falls with clock high to start
// R4: Data rises with clock high to stop
// R5: Eight bits then released ninth ack bit
// R6: Switch acks each byte it receives
// R7: Host acks read bytes that are not last
// R8: Host nacks last read byte, then stops
// R9: Address pins tied by board, set here
// R10: Address last bit: one reads, zero writes
// R11: Switch keeps only the last written byte
// R12: Low nibble bits enable channels zero-three
// R13: New selection takes effect at stop
// R14: Stop right after the control byte ack; code first resends the byte cnt_reg more times
// R15: Reset clears control byte, no channels
// R16: Read returns enables and interrupt nibble
// R17: Any channel interrupt pulls output low
// R18: Interrupts seen on unselected channels too
// R19: High nibble reports channel interrupts zero-three
// R20: Status bit one means input asserted
// R21: Software polls all devices on flagged channel
// R22: Interrupt inputs usable as general inputs
// R23: Reset pin low resets switch, deselects all
// R24: Switch answers only its own address
module switch_host
	import switch_host_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Switch bus clock, open drain
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	// Switch bus data, open drain
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	// Switch side pins
	input  wire logic              switch_irq_n,
	output logic                   dev_rst_n
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	pin_view_if view ();             // Synchronised pins
	logic              tick;         // Quarter bit enable
	state_type         state_reg;    // Transfer sequencer
	logic [1:0]        ph_reg;       // Quarter within a bit
	logic [3:0]        bit_cnt_reg;  // Bit within a byte, 8 is ack
	kind_type          kind_reg;     // Byte being moved
	logic [1:0]        rem_reg;      // Data bytes left after this one
	logic [7:0]        shift_reg;    // Byte shifter
	logic              ack_reg;      // Ack seen on last ninth bit
	logic              rd_dir_reg;   // Transfer is a read
	logic              scl_drive_reg; // Pull clock low
	logic              sda_drive_reg; // Pull data low
	logic              dev_rst_n_reg; // Reset pin to switch
	logic [3:0]        rst_cnt_reg;  // Reset pulse length
	logic              nack_reg;     // Last transfer was refused
	logic [7:0]        rd_byte_reg;  // Last control byte read
	logic [1:0]        sel_reg;      // Address select levels
	logic [1:0]        cnt_reg;      // Extra data bytes per transfer
	logic [7:0]        wbyte_reg;    // Control byte to write
	logic [7:0]        addr_byte;    // Address with direction
	logic              aw_have_reg;  // Write address held
	logic [AXI_AW-1:0] aw_addr_reg;
	logic              w_have_reg;   // Write data held
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              wr_fire;      // Register write this cycle
	logic              ctrl_wr;      // Low lane of control written
	logic              go_wr;        // Write command pulse
	logic              go_rd;        // Read command pulse
	logic              go_rst;       // Reset command pulse
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rd_word;      // Read mux result
	logic              rd_hit;       // Read address mapped

	////////////////////////////////////////////////////////////////////////
	// Helpers
	line_sync u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.irq_in_n (switch_irq_n),
		.view     (view)
	);

	tick_div #(.DIV(QTR_CYC)) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels
	assign awready = !aw_have_reg && !bvalid_reg;
	assign wready  = !w_have_reg && !bvalid_reg;
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign ctrl_wr = wr_fire && (aw_addr_reg == CTRL_OFS) && w_strb_reg[0];
	assign go_wr   = ctrl_wr && w_data_reg[GO_WR_BIT];
	assign go_rd   = ctrl_wr && w_data_reg[GO_RD_BIT];
	assign go_rst  = ctrl_wr && w_data_reg[DEV_RST_BIT];

	// Hold the write address until the data is here too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= awaddr;
		end else if (wr_fire) begin
			aw_have_reg <= 1'b0;
		end
	end

	// Hold the write data until the address is here too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= wdata;
			w_strb_reg <= wstrb;
		end else if (wr_fire) begin
			w_have_reg <= 1'b0;
		end
	end

	// Write response, error for unmapped addresses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			if (aw_addr_reg == CTRL_OFS || aw_addr_reg == WDATA_OFS) begin
				bresp_reg <= RESP_OKAY;
			end else if (aw_addr_reg == STATUS_OFS ||
			             aw_addr_reg == RDATA_OFS) begin
				bresp_reg <= RESP_OKAY;
			end else begin
				bresp_reg <= RESP_SLVERR;
			end
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp  = bresp_reg;

	// Software registers; select pins and count persist
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_reg   <= SEL_RST;
			cnt_reg   <= CNT_RST;
			wbyte_reg <= WDATA_RST;
		end else if (wr_fire) begin
			if (aw_addr_reg == CTRL_OFS) begin
				// Board straps mirrored by software
				if (w_strb_reg[0]) cnt_reg <= w_data_reg[CNT_LSB +: 2];
				if (w_strb_reg[1]) sel_reg <= w_data_reg[SEL_LSB +: 2]; // R9
			end else if (aw_addr_reg == WDATA_OFS && w_strb_reg[0]) begin
				wbyte_reg <= w_data_reg[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign arready = !rvalid_reg;

	// Read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (araddr == CTRL_OFS) begin
			rd_word[CNT_LSB +: 2] = cnt_reg;
			rd_word[SEL_LSB +: 2] = sel_reg;
		end else if (araddr == WDATA_OFS) begin
			rd_word[7:0] = wbyte_reg;
		end else if (araddr == STATUS_OFS) begin
			rd_word[ST_BUSY_BIT] = (state_reg != ST_IDLE);
			rd_word[ST_NACK_BIT] = nack_reg;
			rd_word[ST_IRQ_BIT]  = !view.irq_n_s;
			// Flagged channels for software to poll
			rd_word[ST_FLAG_LSB +: 4] = rd_byte_reg[CHAN_IRQ_LSB +: 4]; // R21
			rd_word[ST_CONN_LSB +: 4] = rd_byte_reg[CHAN_EN_LSB +: 4]; // R16
		end else if (araddr == RDATA_OFS) begin
			rd_word[7:0] = rd_byte_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign rvalid = rvalid_reg;
	assign rdata  = rdata_reg;
	assign rresp  = rresp_reg;

	////////////////////////////////////////////////////////////////////////
	// Transfer sequencer
	// Address byte: fixed bits, strap levels, direction last
	assign addr_byte = {DEV_ADDR_HI, sel_reg, rd_dir_reg}; // R10

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= ST_IDLE;
			ph_reg        <= 2'h0;
			bit_cnt_reg   <= 4'h0;
			kind_reg      <= KIND_ADDR;
			rem_reg       <= 2'h0;
			shift_reg     <= 8'h00;
			ack_reg       <= 1'b0;
			rd_dir_reg    <= 1'b0;
			scl_drive_reg <= 1'b0;
			sda_drive_reg <= 1'b0;
			dev_rst_n_reg <= 1'b1;
			rst_cnt_reg   <= 4'h0;
			nack_reg      <= 1'b0;
			rd_byte_reg   <= 8'h00;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// Reset pulse wins over a transfer request
				if (go_rst) begin
					dev_rst_n_reg <= 1'b0; // R23
					rst_cnt_reg   <= 4'(RST_CYC - 1);
					state_reg     <= ST_RST;
				end else if (go_wr || go_rd) begin
					rd_dir_reg <= go_rd;
					rem_reg    <= cnt_reg;
					nack_reg   <= 1'b0;
					state_reg  <= ST_WAIT_BUS;
				end
			end
			ST_RST: begin
				// Hold the switch reset for the least pulse width
				if (rst_cnt_reg == 4'h0) begin
					dev_rst_n_reg <= 1'b1; // R23
					state_reg     <= ST_IDLE;
				end else begin
					rst_cnt_reg <= rst_cnt_reg - 4'h1;
				end
			end
			ST_WAIT_BUS: begin
				// Begin only on an idle bus, data falls with clock high
				if (tick && view.scl_s && view.sda_s) begin // R1
					sda_drive_reg <= 1'b1; // R3
					state_reg     <= ST_START;
				end
			end
			ST_START: begin
				// Clock low after the start hold, load the address
				if (tick) begin
					scl_drive_reg <= 1'b1;
					shift_reg     <= addr_byte;
					kind_reg      <= KIND_ADDR;
					bit_cnt_reg   <= 4'h0;
					ph_reg        <= 2'h0;
					state_reg     <= ST_BIT;
				end
			end
			ST_BIT: begin
				if (tick) begin
					case (ph_reg)
					2'h0: begin
						// Clock low: set up data
						if (bit_cnt_reg == 4'h8) begin
							// Ack only read bytes that are not last
							sda_drive_reg <= (kind_reg == KIND_RX) &&
							                 (rem_reg != 2'h0); // R5 R7 R8
						end else begin
							sda_drive_reg <= (kind_reg != KIND_RX) &&
							                 !shift_reg[7]; // R2
						end
						ph_reg <= 2'h1;
					end
					2'h1: begin
						// Release clock
						scl_drive_reg <= 1'b0;
						ph_reg        <= 2'h2;
					end
					2'h2: begin
						// Sample once the clock is really high
						if (view.scl_s) begin
							if (bit_cnt_reg == 4'h8) begin
								ack_reg <= !view.sda_s; // R6
							end else begin
								shift_reg <= {shift_reg[6:0], view.sda_s};
							end
							ph_reg <= 2'h3;
						end
					end
					default: begin
						// Clock low, step to the next bit or byte
						scl_drive_reg <= 1'b1;
						ph_reg        <= 2'h0;
						if (bit_cnt_reg != 4'h8) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else begin
							bit_cnt_reg <= 4'h0;
							if (kind_reg != KIND_RX && !ack_reg) begin
								// Address or byte refused
								nack_reg  <= 1'b1;
								state_reg <= ST_STOP;
							end else if (kind_reg == KIND_ADDR) begin
								kind_reg  <= rd_dir_reg ? KIND_RX : KIND_TX;
								shift_reg <= rd_dir_reg ? 8'h00 : wbyte_reg;
							end else begin
								if (kind_reg == KIND_RX) begin
									rd_byte_reg <= shift_reg; // R16
								end
								if (rem_reg == 2'h0) begin
									state_reg <= ST_STOP; // R14
								end else begin
									rem_reg   <= rem_reg - 2'h1;
									shift_reg <= wbyte_reg;
								end
							end
						end
					end
					endcase
				end
			end
			ST_STOP: begin
				if (tick) begin
					case (ph_reg)
					2'h0: begin
						// Data low under a low clock
						sda_drive_reg <= 1'b1;
						ph_reg        <= 2'h1;
					end
					2'h1: begin
						scl_drive_reg <= 1'b0;
						ph_reg        <= 2'h2;
					end
					2'h2: begin
						// Data rises while clock is high
						if (view.scl_s) begin
							sda_drive_reg <= 1'b0; // R4
							ph_reg        <= 2'h3;
						end
					end
					default: begin
						// Bus free time before the next command
						ph_reg    <= 2'h0;
						state_reg <= ST_IDLE;
					end
					endcase
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// Open-drain pins: drive low only
	assign scl_out   = 1'b0;
	assign sda_out   = 1'b0;
	assign scl_oe    = scl_drive_reg;
	assign sda_oe    = sda_drive_reg;
	assign dev_rst_n = dev_rst_n_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wait_then_start;
		state_reg == ST_WAIT_BUS ##1 state_reg == ST_START;
	endsequence

	sequence s_ack_slot;
		state_reg == ST_BIT && bit_cnt_reg == 4'h8 && ph_reg != 2'h0;
	endsequence

	a_start_idle_bus: assert property ( // R1
		s_wait_then_start |-> $past(view.scl_s && view.sda_s))
		else $error("start issued on a busy bus");

	a_data_stable_high: assert property ( // R2
		(state_reg == ST_BIT && !scl_drive_reg && $past(!scl_drive_reg))
		|-> $stable(sda_drive_reg))
		else $error("data moved while clock released");

	a_start_edge_order: assert property ( // R3
		$rose(sda_drive_reg) && !scl_drive_reg |-> state_reg == ST_START)
		else $error("data fell with clock high outside start");

	a_stop_edge_order: assert property ( // R4
		$fell(sda_drive_reg) && !scl_drive_reg
		|-> state_reg == ST_IDLE ##0 $past(state_reg) == ST_STOP
		    or state_reg == ST_STOP)
		else $error("data rose with clock high outside stop");

	a_tx_ack_release: assert property ( // R5
		s_ack_slot and kind_reg != KIND_RX |-> !sda_drive_reg)
		else $error("data held during ninth bit of sent byte");

	a_rx_mid_ack: assert property ( // R7
		s_ack_slot and kind_reg == KIND_RX and rem_reg != 2'h0
		|-> sda_drive_reg)
		else $error("read byte not acknowledged");

	a_rx_last_nack: assert property ( // R8
		s_ack_slot and kind_reg == KIND_RX and rem_reg == 2'h0
		|-> !sda_drive_reg ##1 (state_reg == ST_BIT || state_reg == ST_STOP))
		else $error("last read byte not left high");

	a_addr_dir_bit: assert property ( // R10
		$rose(state_reg == ST_BIT)
		|-> shift_reg == {DEV_ADDR_HI, sel_reg, rd_dir_reg})
		else $error("address byte or direction wrong");

	a_stop_after_ack: assert property ( // R14
		state_reg == ST_BIT && tick && ph_reg == 2'h3 &&
		bit_cnt_reg == 4'h8 && kind_reg == KIND_TX && rem_reg == 2'h0
		|=> state_reg == ST_STOP && ph_reg == 2'h0)
		else $error("no stop after last written byte");

	a_reset_pulse: assert property ( // R23
		$fell(dev_rst_n_reg) |-> !dev_rst_n_reg ##1 dev_rst_n_reg)
		else $error("switch reset pulse wrong length");
endmodule

// *** test/switch_model.sv ***
// Purpose: Behavioural four-channel bus switch on the far side
// Assumes: Bus lines pulled up, pulled low only through enables
// Notes:   Can stretch the clock after each falling edge
`timescale 1ns/10ps
module switch_model
	import switch_host_pkg::*;
(
	// Switch bus
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe,
	output logic            scl_hold,
	// Side pins
	input  wire logic       rst_n,
	input  wire logic       addr_sel_lo,
	input  wire logic       addr_sel_hi,
	input  wire logic [3:0] chan_irq_in_n,
	input  wire logic       stretch,
	output logic            irq_n,
	output logic [3:0]      conn
);
	logic [7:0] ctrl = 8'h00; // Control byte, clear at power-up
	logic [7:0] sh;           // Received bits
	logic [7:0] tx;           // Byte being sent
	logic       me = 0;       // Addressed in this transfer
	logic       rd = 0;       // Read direction
	logic       aph = 0;      // Address byte phase
	logic       nak = 0;      // Host refused a read byte
	int         cnt = 0;      // Rising clock edges in this byte

	initial begin
		sda_oe = 0;
		scl_hold = 0;
		conn = 0;
	end
	// Shared line low while any input low, selected or not
	assign irq_n = &chan_irq_in_n;
	// Start opens, stop connects the new selection
	always @(negedge sda) if (scl === 1'b1) begin
		cnt = 0;
		aph = 1;
		me = 0;
		nak = 0;
		sda_oe = 0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		conn = ctrl[3:0];
		me = 0;
	end
	// Sample data while the clock is high
	always @(posedge scl) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else if (me && rd)
			nak = sda;
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// Change data only while the clock is low
	always @(negedge scl) begin
		if (cnt == 8) begin
			if (aph) begin
				me = sh[7:1] == {DEV_ADDR_HI, addr_sel_hi, addr_sel_lo};
				rd = sh[0];
			end else if (me && !rd)
				ctrl = sh;
			sda_oe = me && (aph || !rd);
			aph = 0;
		end else if (me && rd && !nak) begin
			if (cnt == 0)
				tx = {~chan_irq_in_n, ctrl[3:0]};
			sda_oe = !tx[7 - cnt];
		end else
			sda_oe = 0;
		if (stretch) begin
			scl_hold = 1;
			// Held past the host's release so that it must wait
			#9000 scl_hold = 0;
		end
	end
	// Reset pin clears the byte and deselects all
	always @(negedge rst_n) begin
		ctrl = 0;
		conn = 0;
		me = 0;
		sda_oe = 0;
	end
endmodule

// *** test/i2c_switch_ctrl_irq_test.sv ***
// Purpose: Self-checking bench for the switch host controller
// Assumes: Switch model on the far side, lines pulled up
// Notes:   Registers reached through AXI4-Lite tasks
`timescale 1ns/10ps
module i2c_switch_ctrl_irq_test;
	import switch_host_pkg::*;
	logic        aclk = 0, aresetn = 0, stretch = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'h3, irq_in_n = 4'hf;
	logic [31:0] wdata = 0, d, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq_n;
	logic        scl_oe, sda_oe, m_sda_oe, m_hold, dev_rst_n;
	logic [1:0]  bresp, rresp;
	logic [3:0]  conn, v, old;
	logic [7:0]  e;
	int          errors = 0, total_checks = 0, cycles = 0, i;
	wire         scl = !(scl_oe | m_hold);   // Pulled-up clock line
	wire         sda = !(sda_oe | m_sda_oe); // Pulled-up data line

	switch_host u_switch_host (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .scl_in(scl), .scl_out(),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.switch_irq_n(irq_n), .dev_rst_n(dev_rst_n));
	switch_model u_switch_model (.scl(scl), .sda(sda), .rst_n(dev_rst_n),
		.addr_sel_lo(1'b0), .addr_sel_hi(1'b1), .chan_irq_in_n(irq_in_n),
		.stretch(stretch), .sda_oe(m_sda_oe), .scl_hold(m_hold),
		.irq_n(irq_n), .conn(conn));

	always #50 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] dd,
		input logic [1:0] er);
		logic pa, pw, ta, tw;
		@(posedge aclk); // Let an edge pass after any earlier release
		pa = 1;
		pw = 1;
		awaddr <= a;
		wdata <= dd;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa & awready;
			tw = pw & wready;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			pa &= !ta;
			pw &= !tw;
		end
		do @(negedge aclk); while (!bvalid);
		chk(bresp, er);
		@(posedge aclk);
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
		@(posedge aclk); // Let an edge pass after any earlier release
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 0;
		do @(negedge aclk); while (!rvalid);
		d = rdata;
		chk(rresp, er);
		@(posedge aclk);
		rready <= 0;
	endtask
	// Command word: select pins, extra bytes, reset/read/write
	task automatic run(input logic [1:0] sel, cnt, input logic [2:0] op);
		axi_wr(CTRL_OFS, {22'h0, sel, 2'h0, cnt, 1'b0, op}, RESP_OKAY);
		do axi_rd(STATUS_OFS, RESP_OKAY); while (d[ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic close_out();
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axi_rd(STATUS_OFS, RESP_OKAY);
		chk(d[2:0], 3'h0);
		chk(conn, 4'h0);
		axi_rd(4'h2, RESP_SLVERR);
		chk(d, 32'h0);
		axi_wr(4'h2, 32'h0, RESP_SLVERR);
		// Two-byte writes, second with clock stretching
		for (i = 0; i < 2; i++) begin
			old = conn;
			v = i ? 4'ha : 4'h5;
			stretch <= i[0];
			axi_wr(WDATA_OFS, {28'h0, v}, RESP_OKAY);
			axi_rd(WDATA_OFS, RESP_OKAY);
			chk(d[7:0], {4'h0, v});
			axi_wr(CTRL_OFS, {22'h0, 2'h2, 8'h11}, RESP_OKAY);
			while (u_switch_model.ctrl !== {4'h0, v}) @(posedge aclk);
			chk(conn, old);
			do axi_rd(STATUS_OFS, RESP_OKAY); while (d[ST_BUSY_BIT] !== 1'b0);
			chk(conn, v);
			chk(d[ST_NACK_BIT], 1'b0);
		end
		// Two-byte reads with and without channel interrupts
		for (i = 0; i < 2; i++) begin
			irq_in_n <= i ? 4'hf : 4'h6;
			e = {(i ? 4'h0 : 4'h9), 4'ha};
			run(2'h2, 2'h1, 3'h2);
			chk(d[ST_IRQ_BIT], !i[0]);
			chk(d[15:8], {e[3:0], e[7:4]});
			axi_rd(RDATA_OFS, RESP_OKAY);
			chk(d[7:0], e);
		end
		run(2'h0, 2'h0, 3'h1);
		chk(d[ST_NACK_BIT], 1'b1);
		chk(conn, 4'ha);
		run(2'h2, 2'h0, 3'h4);
		chk(conn, 4'h0);
		run(2'h2, 2'h2, 3'h2);
		chk(d[15:12], 4'h0);
		axi_rd(RDATA_OFS, RESP_OKAY);
		chk(d[7:0], 8'h00);
		close_out();
	end
endmodule
